// ### hdl/asu_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH
`define ASU_OFF_RX_STATUS_CONTROL 8'h00
`define ASU_OFF_TX_HOLDING 8'h04
`define ASU_OFF_TX_STATUS_CONTROL 8'h08
`define ASU_OFF_BAUD_CONTROL 8'h0C
`define ASU_OFF_BAUD_DIVISOR_HIGH 8'h10
`define ASU_OFF_BAUD_DIVISOR_LOW 8'h14
`define ASU_OFF_RX_HOLDING 8'h18
`define ASU_OFF_PERIPHERAL_FLAGS 8'h1C
`define ASU_OFF_PERIPHERAL_IRQ_ENABLES 8'h20
// rx_status_control fields.
`define ASU_RS_PORT_ENABLE 7
`define ASU_RS_RX_NINE 6
`define ASU_RS_SINGLE_RX 5
`define ASU_RS_CONT_RX 4
`define ASU_RS_ADDR_DET 3
`define ASU_RS_FRAMING 2
`define ASU_RS_OVERRUN 1
`define ASU_RS_RX_NINTH 0
// tx_status_control fields.
`define ASU_TS_TX_NINE 6
`define ASU_TS_TX_ENABLE 5
`define ASU_TS_SYNC_MODE 4
`define ASU_TS_HIGH_SPEED 2
`define ASU_TS_SHIFT_EMPTY 1
`define ASU_TS_TX_NINTH 0
// baud_control fields.
`define ASU_BC_RX_IDLE 6
`define ASU_BC_WIDE_BAUD 3
`define ASU_BC_WAKEUP 1
// peripheral_flags and peripheral_irq_enables fields.
`define ASU_PF_RX_READY 5
`define ASU_PF_TX_EMPTY 4
`define ASU_RESET_BYTE 8'h00
`define ASU_TS_RESET 8'h02
// Instruction cycle is four clocks; the empty flag settles after two.
`define ASU_ICYCLE_CLKS 4
`define ASU_TX_BUFFER_EMPTY_FLAG_SETTLE_CLKS (2 * `ASU_ICYCLE_CLKS)
`endif

// ### hdl/asu_pkg.sv
// Types shared by the serial port design.
package asu_pkg;
  typedef enum logic [1:0] {
    ASU_TX_IDLE,
    ASU_TX_START,
    ASU_TX_DATA,
    ASU_TX_STOP
  } asu_tx_state_t;
  typedef enum logic [2:0] {
    ASU_RX_IDLE,
    ASU_RX_START,
    ASU_RX_DATA,
    ASU_RX_STOP,
    ASU_RX_WAKE_LOW
  } asu_rx_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } asu_char_t;
endpackage

// ### hdl/asu_serial_port.sv
// Asynchronous serial transmitter and receiver with wake-up, AXI4-Lite regs.
//
// Overview of operation
// RULE1 - Shift register loads only after stop bit.
// RULE2 - After stop, pending holding byte moves in.
// RULE3 - Transfer takes one cycle, sets empty flag.
// RULE4 - Empty flag cleared only by holding write.
// RULE5 - Empty flag valid two instruction cycles later.
// RULE6 - Shift empty status bit, no interrupt.
// RULE7 - Setting transmit enable sets empty flag.
// RULE8 - Sync clear, port enable set: async pins.
// RULE9 - Ninth transmit bit sent when enabled.
// RULE10 - Holding write starts transmission when enabled.
// RULE11 - Receiver samples pin at sixteen times baud.
// RULE12 - Receive only while continuous receive set.
// RULE13 - Complete character sets ready, gated interrupt.
// RULE14 - Status shows ninth bit and error flags.
// RULE15 - Received byte read from receive holding.
// RULE16 - Clearing continuous receive clears errors.
// RULE17 - Address detect filters; cleared passes all.
// RULE18 - Wake-up enable holds receiver idle watching.
// RULE19 - Wake-up is falling edge, async only; wake_flag also sets with the port off or in sync mode.
// RULE20 - Wake-up event sets receive ready flag.
// RULE21 - Reading receive holding clears wake-up flag.
// RULE22 - Rising edge after wake clears enable.
// RULE23 - Frame: start, eight/nine data, stop, LSB first.
// RULE24 - Generator ticks at sixteen or sixty-four.
// RULE25 - Transmitter and receiver independent, shared baud.
// RULE26 - Address detect loads only ninth-bit-set characters.
// RULE27 - Low stop framing error; full buffer overrun.
// RULE28 - Transmit pin idles high.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "asu_defines.svh"

module asu_serial_port (
  input wire logic aclk, // System clock, 200 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic rx_pin, // Receive pin.
  output logic tx_pin, // Transmit pin.
  output logic tx_irq, // Transmit buffer empty request.
  output logic rx_irq // Receive ready request.
);

  // ==========================================================
  // Registers
  logic [7:0] rx_status_control;
  logic [7:0] tx_status_control;
  logic [7:0] baud_control;
  logic [7:0] baud_divisor_high;
  logic [7:0] baud_divisor_low;
  logic [7:0] tx_holding;
  logic [7:0] peripheral_irq_enables;
  asu_pkg::asu_char_t rx_holding;
  logic tx_buffer_empty_flag;
  logic tx_pending;
  logic rx_full;
  logic framing_error;
  logic overrun_error;
  logic wake_flag;
  logic [3:0] settle_cnt;

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [31:0] rdata_mux;
  logic rd_hit;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane = w_strb[0];
  wire wr_rsc = do_write && wr_lane && aw_addr == `ASU_OFF_RX_STATUS_CONTROL;
  wire wr_txh = do_write && wr_lane && aw_addr == `ASU_OFF_TX_HOLDING;
  wire wr_tsc = do_write && wr_lane && aw_addr == `ASU_OFF_TX_STATUS_CONTROL;
  wire wr_bc = do_write && wr_lane && aw_addr == `ASU_OFF_BAUD_CONTROL;
  wire wr_bdh = do_write && wr_lane && aw_addr == `ASU_OFF_BAUD_DIVISOR_HIGH;
  wire wr_bdl = do_write && wr_lane && aw_addr == `ASU_OFF_BAUD_DIVISOR_LOW;
  wire wr_pie = do_write && wr_lane &&
    aw_addr == `ASU_OFF_PERIPHERAL_IRQ_ENABLES;
  wire wr_hit = aw_addr == `ASU_OFF_RX_STATUS_CONTROL ||
    aw_addr == `ASU_OFF_TX_HOLDING || aw_addr == `ASU_OFF_TX_STATUS_CONTROL ||
    aw_addr == `ASU_OFF_BAUD_CONTROL || aw_addr == `ASU_OFF_BAUD_DIVISOR_HIGH ||
    aw_addr == `ASU_OFF_BAUD_DIVISOR_LOW || aw_addr == `ASU_OFF_RX_HOLDING ||
    aw_addr == `ASU_OFF_PERIPHERAL_FLAGS ||
    aw_addr == `ASU_OFF_PERIPHERAL_IRQ_ENABLES;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_rxh = rd_take && s_axi_araddr == `ASU_OFF_RX_HOLDING;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rdata_mux = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `ASU_OFF_RX_STATUS_CONTROL: rdata_mux[7:0] = {rx_status_control[7:3],
        framing_error, overrun_error, rx_holding.ninth}; // RULE14
      `ASU_OFF_TX_HOLDING: rdata_mux[7:0] = tx_holding;
      `ASU_OFF_TX_STATUS_CONTROL: rdata_mux[7:0] = tx_status_control;
      `ASU_OFF_BAUD_CONTROL: rdata_mux[7:0] = baud_control;
      `ASU_OFF_BAUD_DIVISOR_HIGH: rdata_mux[7:0] = baud_divisor_high;
      `ASU_OFF_BAUD_DIVISOR_LOW: rdata_mux[7:0] = baud_divisor_low;
      `ASU_OFF_RX_HOLDING: rdata_mux[7:0] = rx_holding.data; // RULE15
      `ASU_OFF_PERIPHERAL_FLAGS: begin
        rdata_mux[`ASU_PF_RX_READY] = rx_full || wake_flag;
        rdata_mux[`ASU_PF_TX_EMPTY] = tx_buffer_empty_flag;
      end
      `ASU_OFF_PERIPHERAL_IRQ_ENABLES: rdata_mux[7:0] = peripheral_irq_enables;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_mux;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control decode and baud generator
  wire port_on = rx_status_control[`ASU_RS_PORT_ENABLE] &&
    !tx_status_control[`ASU_TS_SYNC_MODE]; // RULE8 RULE19
  wire tx_on = port_on && tx_status_control[`ASU_TS_TX_ENABLE];
  wire cont_rx = rx_status_control[`ASU_RS_CONT_RX];
  wire wakeup_enable = baud_control[`ASU_BC_WAKEUP];
  wire nine_rx = rx_status_control[`ASU_RS_RX_NINE];
  wire addr_det = rx_status_control[`ASU_RS_ADDR_DET];
  wire high_speed = tx_status_control[`ASU_TS_HIGH_SPEED];
  wire wide_brg = baud_control[`ASU_BC_WIDE_BAUD];
  // Generator runs at x16 when either speed bit is set, otherwise x64.
  wire fast_gen = high_speed || wide_brg; // RULE24
  wire [15:0] divisor = wide_brg ? {baud_divisor_high, baud_divisor_low} :
    {8'h00, baud_divisor_low};
  logic [15:0] brg_cnt;
  logic [1:0] pre_cnt;
  wire brg_tick = brg_cnt == 16'h0000;
  // Sample tick at sixteen times the bit rate, shared by both sides.
  wire os_tick = brg_tick && (fast_gen || pre_cnt == 2'h3); // RULE11 RULE25

  always_ff @(posedge aclk) begin
    if (!aresetn || !port_on) begin
      brg_cnt <= 16'h0000;
      pre_cnt <= 2'h0;
    end else begin
      brg_cnt <= brg_tick ? divisor : brg_cnt - 16'h0001;
      if (brg_tick) begin
        pre_cnt <= pre_cnt + 2'h1;
      end
    end
  end

  // ==========================================================
  // Software register writes
  wire wake_rise;
  wire tx_state_idle;
  wire tx_load;
  wire rx_idle;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_status_control <= `ASU_RESET_BYTE;
      tx_status_control <= `ASU_TS_RESET;
      baud_control <= `ASU_RESET_BYTE;
      baud_divisor_high <= `ASU_RESET_BYTE;
      baud_divisor_low <= `ASU_RESET_BYTE;
      peripheral_irq_enables <= `ASU_RESET_BYTE;
    end else begin
      if (wr_rsc) begin
        rx_status_control <= {w_data[7:3], 3'b000};
      end
      if (wr_tsc) begin
        tx_status_control <= {w_data[7:2], 1'b0, w_data[0]};
      end
      tx_status_control[`ASU_TS_SHIFT_EMPTY] <= tx_state_idle &&
        !tx_load; // RULE6
      if (wr_bc) begin
        baud_control <= {1'b0, 1'b0, 1'b0, w_data[4:3], 1'b0, w_data[1], 1'b0};
      end
      if (wake_rise) begin
        baud_control[`ASU_BC_WAKEUP] <= 1'b0; // RULE22
      end
      baud_control[`ASU_BC_RX_IDLE] <= rx_idle;
      if (wr_bdh) begin
        baud_divisor_high <= w_data[7:0];
      end
      if (wr_bdl) begin
        baud_divisor_low <= w_data[7:0];
      end
      if (wr_pie) begin
        peripheral_irq_enables <= w_data[7:0];
      end
    end
  end

  // ==========================================================
  // Transmitter
  asu_pkg::asu_tx_state_t tx_state;
  logic [8:0] tx_shift_register;
  logic [3:0] tx_bit;
  logic [3:0] tx_os;
  logic tx_ninth_latched;
  logic tx_on_q;
  assign tx_state_idle = tx_state == asu_pkg::ASU_TX_IDLE;
  wire tx_nine = tx_status_control[`ASU_TS_TX_NINE];
  wire tx_bit_end = os_tick && tx_os == 4'hF;
  // Holding moves in only when the shifter is idle or the stop bit ends.
  wire stop_done = tx_state == asu_pkg::ASU_TX_STOP && tx_bit_end; // RULE1
  assign tx_load = tx_on && tx_pending &&
    (tx_state_idle || stop_done); // RULE2
  wire [3:0] tx_last = tx_nine ? 4'd8 : 4'd7;
  wire txh_write = wr_txh && tx_on;

  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_on) begin
      tx_state <= asu_pkg::ASU_TX_IDLE;
      tx_shift_register <= 9'h1FF;
      tx_bit <= 4'h0;
      tx_os <= 4'h0;
      tx_pin <= 1'b1; // RULE28
    end else if (tx_load) begin
      tx_state <= asu_pkg::ASU_TX_START; // RULE3 RULE10
      tx_shift_register <= {tx_status_control[`ASU_TS_TX_NINTH], tx_holding};
      tx_os <= 4'h0;
      tx_bit <= 4'h0;
      tx_pin <= 1'b0; // RULE23
    end else begin
      if (os_tick) begin
        tx_os <= tx_os + 4'h1;
      end
      unique case (tx_state)
        asu_pkg::ASU_TX_IDLE: tx_pin <= 1'b1;
        asu_pkg::ASU_TX_START: if (tx_bit_end) begin
          tx_state <= asu_pkg::ASU_TX_DATA;
          tx_pin <= tx_shift_register[0]; // RULE23
        end
        asu_pkg::ASU_TX_DATA: if (tx_bit_end) begin
          tx_shift_register <= {1'b1, tx_shift_register[8:1]};
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == tx_last) begin
            tx_state <= asu_pkg::ASU_TX_STOP;
            tx_pin <= 1'b1;
          end else begin
            tx_pin <= tx_shift_register[1]; // RULE9
          end
        end
        asu_pkg::ASU_TX_STOP: if (tx_bit_end) begin
          tx_state <= asu_pkg::ASU_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding <= `ASU_RESET_BYTE;
      tx_pending <= 1'b0;
      tx_buffer_empty_flag <= 1'b0;
      settle_cnt <= 4'h0;
      tx_on_q <= 1'b0;
    end else begin
      tx_on_q <= tx_on;
      if (txh_write) begin
        tx_holding <= w_data[7:0];
        tx_pending <= 1'b1;
        settle_cnt <= 4'(`ASU_TX_BUFFER_EMPTY_FLAG_SETTLE_CLKS); // RULE5
      end else if (tx_load || !tx_on) begin
        tx_pending <= 1'b0;
      end
      if (settle_cnt != 4'h0) begin
        settle_cnt <= settle_cnt - 4'h1;
      end
      if (tx_on && !tx_on_q) begin
        tx_buffer_empty_flag <= 1'b1; // RULE7
      end else if (settle_cnt == 4'h1) begin
        tx_buffer_empty_flag <= !tx_pending; // RULE4 RULE5
      end else if (tx_load && settle_cnt == 4'h0) begin
        tx_buffer_empty_flag <= 1'b1; // RULE3
      end
    end
  end

  // ==========================================================
  // Receiver
  asu_pkg::asu_rx_state_t rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_bit;
  logic [3:0] rx_os;
  logic rx_prev;
  assign rx_idle = rx_state == asu_pkg::ASU_RX_IDLE;
  wire rx_mid = os_tick && rx_os == 4'h7;
  wire [3:0] rx_last = nine_rx ? 4'd8 : 4'd7;
  wire rx_fall = rx_prev && !rx_pin;
  assign wake_rise = rx_state == asu_pkg::ASU_RX_WAKE_LOW && rx_pin;
  wire rx_en = port_on && cont_rx; // RULE12
  wire [8:0] rx_word = nine_rx ? rx_shift : {1'b0, rx_shift[8:1]};
  wire rx_done = rx_state == asu_pkg::ASU_RX_STOP && rx_mid;
  wire rx_accept = !addr_det || !nine_rx || rx_word[8]; // RULE17 RULE26

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !port_on) begin
      rx_state <= asu_pkg::ASU_RX_IDLE;
      rx_shift <= 9'h000;
      rx_bit <= 4'h0;
      rx_os <= 4'h0;
    end else if (wakeup_enable) begin
      rx_os <= 4'h0;
      rx_state <= (rx_state == asu_pkg::ASU_RX_WAKE_LOW || rx_fall) ?
        asu_pkg::ASU_RX_WAKE_LOW : asu_pkg::ASU_RX_IDLE; // RULE18 RULE19
      if (wake_rise) begin
        rx_state <= asu_pkg::ASU_RX_IDLE; // RULE22
      end
    end else begin
      if (os_tick) begin
        rx_os <= rx_mid ? 4'h8 : rx_os + 4'h1;
      end
      unique case (rx_state)
        asu_pkg::ASU_RX_IDLE: if (rx_en && !rx_pin) begin
          rx_state <= asu_pkg::ASU_RX_START;
          rx_os <= 4'h0;
        end
        asu_pkg::ASU_RX_START: if (rx_mid) begin
          rx_state <= rx_pin ? asu_pkg::ASU_RX_IDLE : asu_pkg::ASU_RX_DATA;
          rx_bit <= 4'h0;
        end
        asu_pkg::ASU_RX_DATA: if (rx_mid) begin
          rx_shift <= {rx_pin, rx_shift[8:1]}; // RULE23
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == rx_last) begin
            rx_state <= asu_pkg::ASU_RX_STOP;
          end
        end
        asu_pkg::ASU_RX_STOP: if (rx_mid) begin
          rx_state <= asu_pkg::ASU_RX_IDLE;
        end
        asu_pkg::ASU_RX_WAKE_LOW: rx_state <= asu_pkg::ASU_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_holding <= '0;
      rx_full <= 1'b0;
      framing_error <= 1'b0;
      overrun_error <= 1'b0;
      wake_flag <= 1'b0;
    end else begin
      if (rd_rxh) begin
        rx_full <= 1'b0;
        wake_flag <= 1'b0; // RULE21
      end
      if (wakeup_enable && rx_fall && rx_state != asu_pkg::ASU_RX_WAKE_LOW) begin
        wake_flag <= 1'b1; // RULE20
      end
      if (rx_done && rx_accept && !overrun_error) begin
        if (rx_full && !rd_rxh) begin
          overrun_error <= 1'b1; // RULE27
        end else begin
          rx_holding.data <= rx_word[7:0]; // RULE15
          rx_holding.ninth <= rx_word[8]; // RULE14
          rx_full <= 1'b1; // RULE13
          framing_error <= !rx_pin; // RULE27
        end
      end
      if (!cont_rx) begin
        framing_error <= 1'b0; // RULE16
        overrun_error <= 1'b0; // RULE16
      end
    end
  end

  // ==========================================================
  // Interrupt request gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= tx_buffer_empty_flag &&
        peripheral_irq_enables[`ASU_PF_TX_EMPTY]; // RULE3
      rx_irq <= (rx_full || wake_flag) &&
        peripheral_irq_enables[`ASU_PF_RX_READY]; // RULE13
    end
  end

endmodule // asu_serial_port
`default_nettype wire

// ### tb/asu_serial_port_checker.sv
// Checker of bus answers and transmit line timing at the port's pins.
`timescale 1ns/100ps
`default_nettype none
module asu_serial_port_checker (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic s_axi_awvalid, // AW valid.
  input wire logic s_axi_awready, // AW ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic [7:0] s_axi_araddr, // AR address.
  input wire logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // Read response.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic tx_pin // Transmit line.
);
  // ====
  // Properties.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence low_run;
    !tx_pin [*8];
  endsequence
  // A bit lasts sixteen clocks at least, so no line level is shorter.
  tx_low_hold_a: assert property ($fell(tx_pin) |=> low_run)
    else $error("transmit low level too short");
  tx_high_hold_a: assert property ($rose(tx_pin) |=> tx_pin [*8])
    else $error("transmit high level too short");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_code_a: assert property (ar_taken |=>
    s_axi_rresp == ($past(s_axi_araddr[7:2]) > 6'h08 ? 2'b10 : 2'b00))
    else $error("read response code wrong");
  upper_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  shift_busy_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h08 && !tx_pin |=> !s_axi_rdata[1])
    else $error("shift empty shown during frame");
endmodule // asu_serial_port_checker
bind asu_serial_port asu_serial_port_checker checker_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_pin);
`default_nettype wire

// ### tb/asu_peer.sv
// Remote serial node model: drives the receive line, records sent frames.
`timescale 1ns/100ps
`default_nettype none
module asu_peer #(parameter int BIT_CLKS = 32) (
  input wire logic aclk, // System clock.
  input wire logic tx_pin, // Line from the block.
  output logic rx_pin // Line into the block, idles high.
);
  logic nine = 1'b0;
  logic [8:0] sh;
  logic [8:0] got[$];
  initial rx_pin = 1'b1;
  // ====
  // Sends a frame; the stop ends early so a low stop is no new start.
  task automatic send(input logic [8:0] v, input logic stop_ok);
    @(posedge aclk);
    rx_pin <= 1'b0;
    repeat (BIT_CLKS) @(posedge aclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rx_pin <= v[i];
      repeat (BIT_CLKS) @(posedge aclk);
    end
    rx_pin <= stop_ok;
    repeat (BIT_CLKS * 3 / 4) @(posedge aclk);
    rx_pin <= 1'b1;
    repeat (BIT_CLKS * 5 / 4) @(posedge aclk);
  endtask
  task automatic line(input logic v);
    @(posedge aclk);
    rx_pin <= v;
  endtask
  // ====
  // Records frames mid-bit; a low stop drops the frame.
  initial begin
    forever begin
      @(negedge tx_pin);
      sh = 9'h000;
      repeat (BIT_CLKS / 2) @(posedge aclk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT_CLKS) @(posedge aclk);
        sh[i] = tx_pin;
      end
      repeat (BIT_CLKS) @(posedge aclk);
      if (tx_pin === 1'b1) got.push_back(sh);
    end
  end
endmodule // asu_peer
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the serial port: bus, transmit, receive, wake-up.
`timescale 1ns/100ps
`default_nettype none
`include "asu_defines.svh"
module tb;
  localparam logic [7:0] rsc = `ASU_OFF_RX_STATUS_CONTROL,
    txh = `ASU_OFF_TX_HOLDING,
    tsc = `ASU_OFF_TX_STATUS_CONTROL,
    bdc = `ASU_OFF_BAUD_CONTROL,
    rxh = `ASU_OFF_RX_HOLDING,
    flg = `ASU_OFF_PERIPHERAL_FLAGS,
    ien = `ASU_OFF_PERIPHERAL_IRQ_ENABLES;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rx_pin, tx_pin, tx_irq, rx_irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  int errors = 0;
  int checks_done = 0;
  asu_serial_port DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asu_peer #(.BIT_CLKS(32)) peer (.aclk(aclk), .tx_pin(tx_pin),
    .rx_pin(rx_pin));
  // ====
  // Bus tasks and comparison.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a);
    chk(rv, e);
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && rx_irq !== 1'b1; i++) @(posedge aclk);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 1500 && peer.got.size() < n; i++) @(posedge aclk);
    chk(32'(peer.got.size()), 32'(n));
  endtask
  // ====
  // Scenarios.
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      rc(8'(i * 4), i == 2 ? 32'h2 : i == 3 ? 32'h40 : 32'h0);
    end
    bus_rd(8'h24);
    chk(32'(rr), 32'h2);
    $display("register defaults done");
  endtask
  task automatic t_setup();
    bus_wr(`ASU_OFF_BAUD_DIVISOR_LOW, 8'h01);
    bus_wr(rsc, 8'h90);
    bus_wr(tsc, 8'h24);
    rc(flg, 32'h10);
    bus_wr(flg, 8'h00);
    rc(flg, 32'h10);
    chk(32'(tx_irq), 32'h0);
    bus_wr(ien, 8'h30);
    repeat (2) @(posedge aclk);
    chk(32'(tx_irq), 32'h1);
    $display("setup done");
  endtask
  task automatic t_tx();
    peer.got.delete();
    bus_wr(txh, 8'hA4);
    repeat (16) @(posedge aclk);
    bus_wr(txh, 8'h3C);
    repeat (8) @(posedge aclk);
    rc(flg, 32'h0);
    chk(32'(tx_irq), 32'h0);
    rc(tsc, 32'h24);
    wait_got(2);
    chk(32'(peer.got[0]), 32'hA4);
    chk(32'(peer.got[1]), 32'h3C);
    repeat (40) @(posedge aclk);
    rc(tsc, 32'h26);
    rc(flg, 32'h10);
    chk(32'(tx_pin), 32'h1);
    $display("transmit done");
  endtask
  task automatic t_tx9();
    peer.got.delete();
    peer.nine = 1'b1;
    bus_wr(tsc, 8'h65);
    bus_wr(txh, 8'h81);
    wait_got(1);
    chk(32'(peer.got[0]), 32'h181);
    peer.nine = 1'b0;
    bus_wr(tsc, 8'h24);
    $display("nine bit transmit done");
  endtask
  task automatic t_rx();
    peer.send(9'h05A, 1'b1);
    wait_irq(100);
    chk(32'(rx_irq), 32'h1);
    rc(rsc, 32'h90);
    rc(rxh, 32'h5A);
    repeat (3) @(posedge aclk);
    chk(32'(rx_irq), 32'h0);
    $display("receive done");
  endtask
  task automatic t_err();
    peer.send(9'h0F0, 1'b0);
    wait_irq(100);
    rc(rsc, 32'h94);
    bus_rd(rxh);
    bus_wr(rsc, 8'h80);
    rc(rsc, 32'h80);
    bus_wr(rsc, 8'h90);
    peer.send(9'h011, 1'b1);
    peer.send(9'h022, 1'b1);
    rc(rsc, 32'h92);
    rc(rxh, 32'h11);
    bus_wr(rsc, 8'h80);
    rc(rsc, 32'h80);
    peer.send(9'h033, 1'b1);
    chk(32'(rx_irq), 32'h0);
    bus_wr(rsc, 8'h90);
    $display("receive errors done");
  endtask
  task automatic t_addr();
    bus_wr(rsc, 8'hD8);
    peer.nine = 1'b1;
    peer.send(9'h011, 1'b1);
    chk(32'(rx_irq), 32'h0);
    peer.send(9'h1A7, 1'b1);
    wait_irq(100);
    rc(rsc, 32'hD9);
    rc(rxh, 32'hA7);
    bus_wr(rsc, 8'hD0);
    peer.send(9'h033, 1'b1);
    wait_irq(100);
    rc(rxh, 32'h33);
    peer.nine = 1'b0;
    bus_wr(rsc, 8'h90);
    $display("address detect done");
  endtask
  task automatic t_wake();
    bus_wr(bdc, 8'h02);
    peer.line(1'b0);
    repeat (400) @(posedge aclk);
    chk(32'(rx_irq), 32'h1);
    bus_rd(bdc);
    chk(32'(rv[1]), 32'h1);
    peer.line(1'b1);
    repeat (8) @(posedge aclk);
    bus_rd(bdc);
    chk(32'(rv[1]), 32'h0);
    rc(rsc, 32'h90);
    bus_rd(rxh);
    repeat (3) @(posedge aclk);
    chk(32'(rx_irq), 32'h0);
    $display("wake-up done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ====
  // Clock, watchdog and main sequence.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    wrap_up();
  end
  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_setup();
    t_tx();
    t_tx9();
    t_rx();
    t_err();
    t_addr();
    t_wake();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
